// ==== include/tpw_pkg.sv ====
// Purpose: Constants shared by the timer, PWM and watchdog block
// Assumes: Single 200 MHz clock, plain port control
// Notes:   Interrupt line numbers index the irq_lines output
package tpw_pkg;
    localparam int          TPW_CNT_W      = 32;
    localparam int          TPW_PWM_CH     = 6;
    localparam int          TPW_PWM_MATCH  = 7;
    localparam int          TPW_IRQ_W      = 32;
    localparam int          TPW_IRQ_GP0    = 0;
    localparam int          TPW_IRQ_GP1    = 1;
    localparam int          TPW_IRQ_DUAL   = 2;
    localparam int          TPW_IRQ_WDOG   = 9;
    localparam int          TPW_IRQ_PWM    = 19;
    localparam logic [31:0] TPW_WDOG_KEY   = 32'h1ACCE551;
    localparam logic [31:0] TPW_WDOG_RELCK = 32'h00000000;
    localparam logic [31:0] TPW_ZERO32     = 32'h00000000;
    localparam logic [31:0] TPW_ONE32      = 32'h00000001;
    localparam logic [31:0] TPW_MAX16      = 32'h0000FFFF;
    localparam logic [31:0] TPW_MAX32      = 32'hFFFFFFFF;
    localparam logic [1:0]  TPW_ALT_FN0    = 2'h0;
endpackage

// ==== design/tpw_downcnt.sv ====
// Purpose: One down-counter used by the general-purpose and dual timers
// Assumes: Asynchronous active-low reset, synchronized copy from the top
// Notes:   wrap_max wraps zero to maximum for free-running use
`timescale 1ns/10ps
module tpw_downcnt
    import tpw_pkg::*;
#(
    parameter int WIDTH = 32
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             run,
    input  wire logic             tick,
    input  wire logic             wide,
    input  wire logic             stop_at_zero,
    input  wire logic             wrap_max,
    input  wire logic             load_wr,
    input  wire logic [WIDTH-1:0] load_val,
    input  wire logic [WIDTH-1:0] reload_val,
    output logic      [WIDTH-1:0] count_q,
    output logic                  zero_pulse_q,
    output logic                  halted_q
);
    initial begin
        if (WIDTH != 32) $error("tpw_downcnt needs WIDTH 32");
    end

    logic [WIDTH-1:0] mask;
    logic [WIDTH-1:0] cur;
    logic             at_zero;
    assign mask    = wide ? TPW_MAX32 : TPW_MAX16;
    assign cur     = count_q & mask;
    assign at_zero = (cur == TPW_ZERO32);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_q      <= TPW_ZERO32;
            zero_pulse_q <= 1'b0;
            halted_q     <= 1'b0;
        end else begin
            zero_pulse_q <= 1'b0;
            if (load_wr) begin
                count_q  <= load_val & mask;
                halted_q <= 1'b0;
            end else if (run && tick && !halted_q) begin
                if (cur == TPW_ONE32) begin
                    count_q      <= TPW_ZERO32;
                    zero_pulse_q <= 1'b1;
                    halted_q     <= stop_at_zero;
                end else if (at_zero) begin
                    count_q <= wrap_max ? mask : (reload_val & mask);
                end else begin
                    count_q <= (cur - TPW_ONE32) & mask;
                end
            end
        end
    end
endmodule // tpw_downcnt

// ==== design/tpw_top.sv ====
// What this block does
// [RULE1] Two 32-bit general-purpose down-counters raise timeout on reaching zero.
// [RULE2] General timers count bus clock, or external pin as clock or enable.
// [RULE3] External inputs arrive on pin a and pin b, alternate function 0.
// [RULE4] External clock select plus run counts on external pin edges.
// [RULE5] External gate select plus run counts only while pin is high.
// [RULE6] Software writes current count and reload; run bit starts counting.
// [RULE7] On zero the general timer reloads and continues while running.
// [RULE8] General timer timeout interrupt only when its enable bit is set.
// [RULE9] Dual timer has two counters, 16 or 32 bit, interrupting at zero.
// [RULE10] Dual counters run free, one-shot or periodic by two select bits.
// [RULE11] Dual counters load from software value, run and interrupt enabled.
// [RULE12] PWM drives six channels from one counter and seven matches.
// [RULE13] Channel outputs only when enabled; edge type bit selects double edge; code never drives channel 0 high with its edge type bit set.
// [RULE14] PWM counter advances through a 32-bit prescaler.
// [RULE15] Working match values reload only for load-enabled entries; code loads every entry from its shadow while the counter is stopped.
// [RULE16] Match action bits decide how each match affects channel outputs; code uses them only for counter reset and interrupt.
// [RULE17] PWM match interrupts only for matches with interrupt action bits.
// [RULE18] PWM counter runs only while counter run bit is one.
// [RULE19] Watchdog requests system reset on timeout when reset enabled; code requests it only on a second timeout with no reload write between.
// [RULE20] Watchdog also works as interval timer raising periodic interrupts.
// [RULE21] Watchdog interrupt goes out as a non-maskable interrupt.
// [RULE22] Watchdog ignores register writes while locked.
// [RULE23] Writing the unlock key opens watchdog register writes.
// [RULE24] Writing zero to the lock register locks the watchdog again.
// [RULE25] Interrupts go to lines 0, 1, 2, 9 and 19.
// [RULE26] One-shot stops at zero, periodic reloads, free-running wraps to max.
// Purpose: Timers, dual timer, PWM and watchdog
// Assumes: Controls are plain ports held by software logic
// Notes:   Outputs registered; pins sampled synchronously
`timescale 1ns/10ps
module tpw_top
    import tpw_pkg::*;
#(
    parameter int NCH = TPW_PWM_CH,
    parameter int NMT = TPW_PWM_MATCH
) (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic [1:0]  pin_a_altfn,
    input  wire logic [1:0]  pin_b_altfn,
    input  wire logic        ext_input_pin_a,
    input  wire logic        ext_input_pin_b,
    input  wire logic [1:0]  timer_run_bit,
    input  wire logic [1:0]  external_clock_select,
    input  wire logic [1:0]  external_gate_select,
    input  wire logic [1:0]  gp_int_enable,
    input  wire logic [1:0]  gp_current_wr,
    input  wire logic [31:0] gp0_current_val,
    input  wire logic [31:0] gp1_current_val,
    input  wire logic [31:0] gp0_reload_val,
    input  wire logic [31:0] gp1_reload_val,
    input  wire logic [1:0]  dual_run_bit,
    input  wire logic [1:0]  dual_wide_select,
    input  wire logic [1:0]  dual_single_run,
    input  wire logic [1:0]  dual_periodic,
    input  wire logic [1:0]  dual_int_enable,
    input  wire logic [1:0]  dual_load_wr,
    input  wire logic [31:0] dual_load_value0,
    input  wire logic [31:0] dual_load_value1,
    input  wire logic [5:0]  channel_output_enable,
    input  wire logic [5:0]  edge_type_select,
    input  wire logic [31:0] prescale_reg,
    input  wire logic [6:0]  load_enable_reg,
    input  wire logic [20:0] match_action_reg,
    input  wire logic        counter_run_bit,
    input  wire logic [6:0]  match_wr,
    input  wire logic [31:0] match_wdata,
    input  wire logic        wdog_wr,
    input  wire logic        wdog_lock_wr,
    input  wire logic [31:0] wdog_wdata,
    input  wire logic        wdog_int_enable_in,
    input  wire logic        wdog_reset_enable_in,
    output logic [31:0]      gp0_count,
    output logic [31:0]      gp1_count,
    output logic [31:0]      dual_count0,
    output logic [31:0]      dual_count1,
    output logic [31:0]      pwm_count,
    output logic [5:0]       pwm_out,
    output logic             wdog_locked,
    output logic             wdog_nmi,
    output logic             wdog_reset_req,
    output logic [31:0]      irq_lines
);
    initial begin
        if (NCH != TPW_PWM_CH || NMT != TPW_PWM_MATCH) $error("tpw_top needs 6 ch, 7 matches");
    end

    logic rst_s1_q, rst_n_q;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_s1_q <= 1'b0;
            rst_n_q  <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n_q  <= rst_s1_q;
        end
    end

    // General-purpose timers
    logic [1:0]  pin_raw, pin_q, pin_d1_q;
    logic [1:0]  gp_tick, gp_zero, gp_irq_q;
    logic [31:0] gp_cnt [2];
    assign pin_raw[0] = ext_input_pin_a & (pin_a_altfn == TPW_ALT_FN0); // [RULE3]
    assign pin_raw[1] = ext_input_pin_b & (pin_b_altfn == TPW_ALT_FN0); // [RULE3]
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            pin_q    <= 2'h0;
            pin_d1_q <= 2'h0;
        end else begin
            pin_q    <= pin_raw;
            pin_d1_q <= pin_q;
        end
    end
    genvar g;
    for (g = 0; g < 2; g++) begin : g_gp
        assign gp_tick[g] = external_clock_select[g] ? (pin_q[g] & ~pin_d1_q[g]) : // [RULE4]
                            external_gate_select[g]  ? pin_q[g] : 1'b1;           // [RULE2] [RULE5]
        tpw_downcnt #(.WIDTH(TPW_CNT_W)) u_gp (
            .clk          (clk),
            .rst_n        (rst_n_q),
            .run          (timer_run_bit[g]),                 // [RULE6]
            .tick         (gp_tick[g]),
            .wide         (1'b1),                             // [RULE1]
            .stop_at_zero (1'b0),
            .wrap_max     (1'b0),                             // [RULE7]
            .load_wr      (gp_current_wr[g]),                 // [RULE6]
            .load_val     (g == 0 ? gp0_current_val : gp1_current_val),
            .reload_val   (g == 0 ? gp0_reload_val : gp1_reload_val),
            .count_q      (gp_cnt[g]),
            .zero_pulse_q (gp_zero[g]),
            .halted_q     ()
        );
    end
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) gp_irq_q <= 2'h0;
        else          gp_irq_q <= gp_zero & gp_int_enable;    // [RULE1] [RULE8]
    end

    // Dual timer
    logic [1:0]  du_zero, du_irq_q;
    logic [31:0] du_cnt [2];
    for (g = 0; g < 2; g++) begin : g_du
        tpw_downcnt #(.WIDTH(TPW_CNT_W)) u_du (
            .clk          (clk),
            .rst_n        (rst_n_q),
            .run          (dual_run_bit[g]),                  // [RULE11]
            .tick         (1'b1),
            .wide         (dual_wide_select[g]),              // [RULE9]
            .stop_at_zero (dual_single_run[g]),               // [RULE10] [RULE26]
            .wrap_max     (~dual_single_run[g] & ~dual_periodic[g]), // [RULE26]
            .load_wr      (dual_load_wr[g]),                  // [RULE11]
            .load_val     (g == 0 ? dual_load_value0 : dual_load_value1),
            .reload_val   (g == 0 ? dual_load_value0 : dual_load_value1),
            .count_q      (du_cnt[g]),
            .zero_pulse_q (du_zero[g]),
            .halted_q     ()
        );
    end
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) du_irq_q <= 2'h0;
        else          du_irq_q <= du_zero & dual_int_enable;  // [RULE9] [RULE11]
    end

    // PWM
    logic [31:0] pre_q, pcnt_q;
    logic [31:0] mshadow_q [7];
    logic [31:0] mwork_q [7];
    logic [6:0]  mhit;
    logic [5:0]  pwm_q;
    logic        pwm_irq_q, pstep, preset_cnt;
    assign pstep = counter_run_bit && (pre_q >= prescale_reg);  // [RULE14] [RULE18]
    for (g = 0; g < 7; g++) begin : g_hit
        assign mhit[g] = pstep && (pcnt_q == mwork_q[g]);
    end
    always_comb begin
        preset_cnt = 1'b0;
        for (int i = 0; i < 7; i++) begin
            if (mhit[i] && match_action_reg[3*i+1]) preset_cnt = 1'b1; // [RULE16]
        end
    end
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            pre_q  <= TPW_ZERO32;
            pcnt_q <= TPW_ZERO32;
        end else if (counter_run_bit) begin                   // [RULE18]
            pre_q <= pstep ? TPW_ZERO32 : pre_q + TPW_ONE32;  // [RULE14]
            if (pstep) begin
                pcnt_q <= preset_cnt ? TPW_ZERO32 : pcnt_q + TPW_ONE32; // [RULE12]
            end
        end
    end
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            for (int i = 0; i < 7; i++) begin
                mshadow_q[i] <= TPW_ZERO32;
                mwork_q[i]   <= TPW_ZERO32;
            end
        end else begin
            for (int i = 0; i < 7; i++) begin
                if (match_wr[i]) mshadow_q[i] <= match_wdata;
                if (!counter_run_bit || (preset_cnt && load_enable_reg[i])) begin
                    mwork_q[i] <= match_wr[i] ? match_wdata : mshadow_q[i]; // [RULE15]
                end
            end
        end
    end
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            pwm_q <= 6'h0;
        end else begin
            for (int c = 0; c < 6; c++) begin
                if (!channel_output_enable[c]) begin          // [RULE13]
                    pwm_q[c] <= 1'b0;
                end else if (edge_type_select[c]) begin       // [RULE13]
                    if (mhit[c+1] && c > 0) pwm_q[c] <= 1'b0;
                    else if (c > 0 && mhit[c]) pwm_q[c] <= 1'b1;
                    else if (mhit[0]) pwm_q[c] <= 1'b0;
                end else begin
                    if (mhit[c+1]) pwm_q[c] <= 1'b0;          // [RULE12]
                    else if (mhit[0]) pwm_q[c] <= 1'b1;
                end
            end
        end
    end
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            pwm_irq_q <= 1'b0;
        end else begin
            pwm_irq_q <= 1'b0;
            for (int i = 0; i < 7; i++) begin
                if (mhit[i] && match_action_reg[3*i]) pwm_irq_q <= 1'b1; // [RULE17]
            end
        end
    end

    // Watchdog
    logic        wlock_q, wint_en_q, wrst_en_q, wexp1_q, wnmi_q, wrst_q;
    logic [31:0] wload_q, wcnt_q;
    logic        wopen;
    assign wopen = wdog_wr && !wlock_q;                       // [RULE22]
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            wlock_q <= 1'b1;
        end else if (wdog_lock_wr) begin
            if (wdog_wdata == TPW_WDOG_KEY)        wlock_q <= 1'b0; // [RULE23]
            else if (wdog_wdata == TPW_WDOG_RELCK) wlock_q <= 1'b1; // [RULE24]
        end
    end
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            wload_q   <= TPW_MAX32;
            wint_en_q <= 1'b0;
            wrst_en_q <= 1'b0;
        end else if (wopen) begin                             // [RULE22] [RULE23]
            wload_q   <= wdog_wdata;
            wint_en_q <= wdog_int_enable_in;
            wrst_en_q <= wdog_reset_enable_in;
        end
    end
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            wcnt_q  <= TPW_MAX32;
            wexp1_q <= 1'b0;
            wnmi_q  <= 1'b0;
            wrst_q  <= 1'b0;
        end else begin
            wnmi_q <= 1'b0;
            if (wopen) begin
                wcnt_q <= wdog_wdata;
            end else if (wint_en_q) begin
                if (wcnt_q == TPW_ZERO32) begin
                    wcnt_q <= wload_q;
                    wnmi_q <= 1'b1;                           // [RULE20] [RULE21]
                    if (wexp1_q && wrst_en_q) wrst_q <= 1'b1; // [RULE19]
                    wexp1_q <= 1'b1;
                end else begin
                    wcnt_q <= wcnt_q - TPW_ONE32;
                end
            end
            if (wopen) wexp1_q <= 1'b0;
        end
    end

    // Outputs
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            gp0_count      <= TPW_ZERO32;
            gp1_count      <= TPW_ZERO32;
            dual_count0    <= TPW_ZERO32;
            dual_count1    <= TPW_ZERO32;
            pwm_count      <= TPW_ZERO32;
            pwm_out        <= 6'h0;
            wdog_locked    <= 1'b1;
            wdog_nmi       <= 1'b0;
            wdog_reset_req <= 1'b0;
            irq_lines      <= TPW_ZERO32;
        end else begin
            gp0_count      <= gp_cnt[0];
            gp1_count      <= gp_cnt[1];
            dual_count0    <= du_cnt[0];
            dual_count1    <= du_cnt[1];
            pwm_count      <= pcnt_q;
            pwm_out        <= pwm_q;
            wdog_locked    <= wlock_q;
            wdog_nmi       <= wnmi_q;                         // [RULE21]
            wdog_reset_req <= wrst_q;
            irq_lines                <= TPW_ZERO32;
            irq_lines[TPW_IRQ_GP0]   <= gp_irq_q[0];          // [RULE25]
            irq_lines[TPW_IRQ_GP1]   <= gp_irq_q[1];
            irq_lines[TPW_IRQ_DUAL]  <= |du_irq_q;
            irq_lines[TPW_IRQ_WDOG]  <= wnmi_q;
            irq_lines[TPW_IRQ_PWM]   <= pwm_irq_q;
        end
    end
endmodule // tpw_top

// ==== verification/tpw_top_properties.sv ====
// Purpose: Port-level properties of the timer, PWM and watchdog block
// Assumes: One clock, reset_n active low
// Notes:   Bound to tpw_top
`timescale 1ns/10ps
module tpw_top_properties
    import tpw_pkg::*;
#(
    parameter int NCH = TPW_PWM_CH,
    parameter int NMT = TPW_PWM_MATCH
) (
    input wire logic        clk,
    input wire logic        reset_n,
    input wire logic [1:0]  timer_run_bit,
    input wire logic [1:0]  gp_int_enable,
    input wire logic [1:0]  gp_current_wr,
    input wire logic [1:0]  dual_run_bit,
    input wire logic [1:0]  dual_load_wr,
    input wire logic [5:0]  channel_output_enable,
    input wire logic        counter_run_bit,
    input wire logic        wdog_lock_wr,
    input wire logic [31:0] wdog_wdata,
    input wire logic [31:0] gp0_count,
    input wire logic [31:0] dual_count0,
    input wire logic [31:0] pwm_count,
    input wire logic [5:0]  pwm_out,
    input wire logic        wdog_locked,
    input wire logic        wdog_nmi,
    input wire logic        wdog_reset_req,
    input wire logic [31:0] irq_lines
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    a_gp_irq_gate: assert property (irq_lines[TPW_IRQ_GP0] |-> $past(gp_int_enable[0], 2))
        else $error("gp0 timeout while its enable was low");
    a_gp_count_hold: assert property ((!timer_run_bit[0] && !gp_current_wr[0]) [*4]
        |-> $stable(gp0_count))
        else $error("gp0 count moved while stopped");
    a_dual_count_hold: assert property ((!dual_run_bit[0] && !dual_load_wr[0]) [*4]
        |-> $stable(dual_count0))
        else $error("dual count moved while stopped");
    a_pwm_count_hold: assert property (!counter_run_bit [*4] |-> $stable(pwm_count))
        else $error("pwm count moved while stopped");
    a_pwm_chan_off: assert property ((channel_output_enable == 6'h00) [*3]
        |-> (pwm_out == 6'h00))
        else $error("pwm output active with all channels disabled");
    a_irq_line_map: assert property ((irq_lines & 32'hFFF7FDF8) == 32'h00000000)
        else $error("interrupt on an unassigned line");
    a_nmi_one_cycle: assert property (wdog_nmi |=> !wdog_nmi)
        else $error("nmi longer than one cycle");
    a_reset_req_sticky: assert property (wdog_reset_req |=> wdog_reset_req)
        else $error("reset request dropped");
    a_unlock_key: assert property ((wdog_lock_wr && wdog_wdata == TPW_WDOG_KEY)
        |-> ##[1:3] !wdog_locked)
        else $error("key did not unlock watchdog");
    a_relock_zero: assert property ((wdog_lock_wr && wdog_wdata == TPW_WDOG_RELCK)
        |-> ##[1:3] wdog_locked)
        else $error("zero did not lock watchdog");
    a_locked_start: assert property ($rose(reset_n) |-> wdog_locked)
        else $error("watchdog unlocked after reset");

    c_gp_irq: cover property (irq_lines[TPW_IRQ_GP0]);
    c_nmi: cover property (wdog_nmi);
    c_pwm_irq: cover property (irq_lines[TPW_IRQ_PWM]);
endmodule // tpw_top_properties

bind tpw_top tpw_top_properties #(.NCH(NCH), .NMT(NMT)) u_props (.*);

// ==== verification/tpw_top_tb.sv ====
// Purpose: Self-checking bench for the timer, PWM and watchdog block
// Assumes: 200 MHz clock, inputs driven by non-blocking assignment at rising edges
// Notes:   One task per scenario
`timescale 1ns/10ps
module tpw_top_tb
    import tpw_pkg::*;
;
    logic        clk = 1'h0, reset_n = 1'h0, ext_input_pin_a = 1'h0, ext_input_pin_b = 1'h0;
    logic        counter_run_bit = 1'h0, wdog_wr = 1'h0, wdog_lock_wr = 1'h0;
    logic        wdog_int_enable_in = 1'h0, wdog_reset_enable_in = 1'h0;
    logic [1:0]  pin_a_altfn = 2'h0, pin_b_altfn = 2'h0, timer_run_bit = 2'h0;
    logic [1:0]  external_clock_select = 2'h0, external_gate_select = 2'h0;
    logic [1:0]  gp_int_enable = 2'h0, gp_current_wr = 2'h0, dual_run_bit = 2'h0;
    logic [1:0]  dual_wide_select = 2'h0, dual_single_run = 2'h0, dual_periodic = 2'h0;
    logic [1:0]  dual_int_enable = 2'h0, dual_load_wr = 2'h0;
    logic [5:0]  channel_output_enable = 6'h00, edge_type_select = 6'h00;
    logic [6:0]  load_enable_reg = 7'h00, match_wr = 7'h00;
    logic [20:0] match_action_reg = 21'h000000;
    logic [31:0] gp0_current_val = 32'h0, gp1_current_val = 32'h0, gp0_reload_val = 32'h0;
    logic [31:0] gp1_reload_val = 32'h0, dual_load_value0 = 32'h0, dual_load_value1 = 32'h0;
    logic [31:0] prescale_reg = 32'h0, match_wdata = 32'h0, wdog_wdata = 32'h0;
    logic [31:0] gp0_count, gp1_count, dual_count0, dual_count1, pwm_count, irq_lines;
    logic [5:0]  pwm_out;
    logic        wdog_locked, wdog_nmi, wdog_reset_req;
    int          failures = 0, comparisons = 0;

    tpw_top u_dut (.*);

    initial begin
        forever #2.5 clk = ~clk;
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Cycles until line i is high (32 nmi, 33 reset request), 0 if never
    task automatic wait_sig(input int i, input int lim, output int n);
        for (int k = 1; k <= lim; k++) begin
            @(posedge clk);
            #1;
            if ((i == 32 ? wdog_nmi : i == 33 ? wdog_reset_req : irq_lines[i]) === 1'b1) begin
                n = k;
                return;
            end
        end
        n = 0;
    endtask

    task automatic t_gp();
        int n;
        @(posedge clk);
        gp0_reload_val <= 32'h5;
        gp0_current_val <= 32'h2;
        gp_int_enable <= 2'h1;
        gp_current_wr <= 2'h1;
        timer_run_bit <= 2'h1;
        @(posedge clk);
        gp_current_wr <= 2'h0;
        wait_sig(TPW_IRQ_GP0, 12, n);
        check("gp0 first timeout", 32'h4, 32'(n));
        check("gp0 reload value", 32'h5, gp0_count);
        wait_sig(TPW_IRQ_GP0, 12, n);
        check("gp0 reload period", 32'h6, 32'(n));
        @(posedge clk);
        gp_int_enable <= 2'h0;
        wait_sig(TPW_IRQ_GP0, 20, n);
        check("gp0 masked timeout", 32'h0, 32'(n));
        timer_run_bit <= 2'h0;
    endtask

    task automatic pulse_b(input int w);
        {ext_input_pin_a, ext_input_pin_b} <= 2'h3;
        repeat (w) @(posedge clk);
        {ext_input_pin_a, ext_input_pin_b} <= 2'h0;
        repeat (w + 4) @(posedge clk);
    endtask

    task automatic t_ext();
        @(posedge clk);
        gp0_current_val <= 32'h100;
        gp1_current_val <= 32'h100;
        gp_current_wr <= 2'h3;
        external_clock_select <= 2'h3;
        timer_run_bit <= 2'h3;
        @(posedge clk);
        gp_current_wr <= 2'h0;
        repeat (6) @(posedge clk);
        check("gp1 no pin edges", 32'h100, gp1_count);
        repeat (3) pulse_b(4);
        check("gp1 pin clock", 32'hFD, gp1_count);
        check("gp0 pin clock", 32'hFD, gp0_count);
        timer_run_bit <= 2'h2;
        pin_b_altfn <= 2'h1;
        repeat (2) pulse_b(4);
        check("gp1 pin unrouted", 32'hFD, gp1_count);
        pin_b_altfn <= 2'h0;
        external_clock_select <= 2'h0;
        external_gate_select <= 2'h2;
        repeat (8) @(posedge clk);
        check("gp1 gate low", 32'hFD, gp1_count);
        pulse_b(10);
        check("gp1 gate high", 32'hF3, gp1_count);
        timer_run_bit <= 2'h0;
        external_gate_select <= 2'h0;
    endtask

    task automatic dual_load(input logic [31:0] v);
        @(posedge clk);
        dual_load_value0 <= v;
        dual_load_value1 <= v;
        dual_load_wr <= 2'h3;
        dual_run_bit <= 2'h3;
        @(posedge clk);
        dual_load_wr <= 2'h0;
    endtask

    task automatic t_dual();
        int n;
        dual_wide_select <= 2'h3;
        dual_single_run <= 2'h3;
        dual_int_enable <= 2'h3;
        dual_load(32'h3);
        wait_sig(TPW_IRQ_DUAL, 12, n);
        check("dual one-shot fires", 32'h1, 32'(n != 0));
        wait_sig(TPW_IRQ_DUAL, 20, n);
        check("dual one-shot halts", 32'h0, 32'(n));
        check("dual one-shot count", 32'h0, dual_count0);
        dual_single_run <= 2'h0;
        dual_periodic <= 2'h3;
        dual_load(32'h4);
        wait_sig(TPW_IRQ_DUAL, 12, n);
        wait_sig(TPW_IRQ_DUAL, 12, n);
        check("dual periodic span", 32'h5, 32'(n));
        dual_periodic <= 2'h0;
        dual_wide_select <= 2'h0;
        dual_load(32'h1);
        wait_sig(TPW_IRQ_DUAL, 12, n);
        check("dual 16-bit wrap", 32'hF, 32'(dual_count0[31:12]));
        check("dual1 16-bit wrap", 32'hF, 32'(dual_count1[31:12]));
        dual_run_bit <= 2'h0;
    endtask

    task automatic t_pwm();
        logic [31:0] mv[4] = '{32'h9, 32'h4, 32'h2, 32'h6};
        int          n, h0, h2;
        logic [5:0]  oth;
        channel_output_enable <= 6'h05;
        edge_type_select <= 6'h04;
        load_enable_reg <= 7'h0F;
        match_action_reg <= 21'h000003;
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            match_wr <= 7'(1 << i);
            match_wdata <= mv[i];
        end
        @(posedge clk);
        match_wr <= 7'h00;
        counter_run_bit <= 1'h1;
        wait_sig(TPW_IRQ_PWM, 20, n);
        wait_sig(TPW_IRQ_PWM, 20, n);
        check("pwm period", 32'hA, 32'(n));
        check("pwm count restart", 32'h0, pwm_count);
        h0 = 0;
        h2 = 0;
        oth = 6'h00;
        for (int k = 0; k < 10; k++) begin
            @(posedge clk);
            #1;
            h0 += int'(pwm_out[0]);
            h2 += int'(pwm_out[2]);
            oth |= pwm_out & 6'h3A;
        end
        check("pwm single edge width", 32'h5, 32'(h0));
        check("pwm double edge width", 32'h4, 32'(h2));
        check("pwm disabled channels", 32'h0, 32'(oth));
        prescale_reg <= 32'h1;
        wait_sig(TPW_IRQ_PWM, 40, n);
        wait_sig(TPW_IRQ_PWM, 40, n);
        check("pwm prescaled period", 32'h14, 32'(n));
        match_action_reg <= 21'h000002;
        wait_sig(TPW_IRQ_PWM, 50, n);
        check("pwm irq off", 32'h0, 32'(n));
        counter_run_bit <= 1'h0;
    endtask

    task automatic wd(input logic lk, input logic [31:0] v);
        @(posedge clk);
        wdog_lock_wr <= lk;
        wdog_wr <= ~lk;
        wdog_wdata <= v;
        @(posedge clk);
        wdog_lock_wr <= 1'h0;
        wdog_wr <= 1'h0;
        repeat (3) @(posedge clk);
    endtask

    task automatic t_wdog();
        int n;
        wdog_int_enable_in <= 1'h1;
        wdog_reset_enable_in <= 1'h1;
        wd(1'h0, 32'h5);
        wait_sig(32, 30, n);
        check("wdog locked write", 32'h0, 32'(n));
        check("wdog locked", 32'h1, 32'(wdog_locked));
        wd(1'h1, TPW_WDOG_KEY);
        check("wdog unlocked", 32'h0, 32'(wdog_locked));
        wd(1'h0, 32'h5);
        wait_sig(32, 20, n);
        check("wdog interval nmi", 32'h1, 32'(n != 0));
        wait_sig(33, 30, n);
        check("wdog reset request", 32'h1, 32'(n != 0));
        wd(1'h1, TPW_WDOG_RELCK);
        check("wdog relocked", 32'h1, 32'(wdog_locked));
    endtask

    task automatic conclude();
        $display("failures=%0d comparisons=%0d", failures, comparisons);
        if (failures == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (8) @(posedge clk);
        reset_n <= 1'h1;
        repeat (3) @(posedge clk);
        t_gp();
        t_ext();
        t_dual();
        t_pwm();
        t_wdog();
        conclude();
    end

    initial begin
        #10000;
        failures++;
        conclude();
    end
endmodule // tpw_top_tb
